// ===== video_level_color_adjust_bench.sv
// Self-checking bench of the adjuster
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error %0t got %h exp %h", $time, g, e); end end
module video_level_color_adjust_bench;
	import vpa_pkg::*;
	logic        sys_clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
	logic        vid_valid_i, vid_ready_o, vid_sof_i, out_valid_o, out_ready_i, out_sof_o;
	logic [5:0]  wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [9:0]  vid_y_i, vid_cb_i, vid_cr_i, out_y_o, out_cb_o, out_cr_o;
	logic [30:0] expq[$];
	logic [30:0] exp_w;
	int          err_count, n_checks, cyc_n;
	int          seed = 32'h938CBB93;
	vpa_top DUT (.sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .vid_valid_i, .vid_ready_o, .vid_sof_i, .vid_y_i,
		.vid_cb_i, .vid_cr_i, .out_valid_o, .out_ready_i, .out_sof_o, .out_y_o, .out_cb_o,
		.out_cr_o);
	vpa_sink PEER (.sys_clk_i, .rstn_i, .slow_i(slow), .ready_o(out_ready_i));
	// Free running clock
	initial begin
		sys_clk_i = 1'b0;
		forever #5 sys_clk_i = ~sys_clk_i;
	end
	task automatic summarize();
		if (err_count == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One classic bus cycle, held until ack however long it takes
	task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge sys_clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, d, s};
		@(posedge sys_clk_i);
		while (!wb_ack_o) @(posedge sys_clk_i);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'b00;
	endtask
	task automatic rchk(input logic [5:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hF);
		`CHK(rd, e)
	endtask
	// One frame; ey below zero means bypass, so output equals input
	task automatic frame(input int n, input int ey);
		logic [29:0] s;
		@(posedge sys_clk_i);
		for (int i = 0; i < n; i++) begin
			s = 30'(($random(seed) & 30'h1FF7FDFF) | 30'h04010040);
			{vid_sof_i, vid_y_i, vid_cb_i, vid_cr_i, vid_valid_i} <= {i == 0, s, 1'b1};
			expq.push_back(ey < 0 ? {i == 0, s} : {i == 0, ey[9:0], 20'h80200});
			@(posedge sys_clk_i);
			while (!vid_ready_o) @(posedge sys_clk_i);
		end
		vid_valid_i <= 1'b0;
		while (expq.size() != 0) @(posedge sys_clk_i);
	endtask
	// Scoreboard: oldest note against each accepted output sample
	always @(posedge sys_clk_i) begin
		if (rstn_i && out_valid_o && out_ready_i) begin
			exp_w = expq.pop_front();
			`CHK({out_sof_o, out_y_o, out_cb_o, out_cr_o}, exp_w)
		end
	end
	// Cycle ceiling so a hang still ends in a verdict
	always @(posedge sys_clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			err_count++;
			summarize();
		end
	end
	initial begin
		{rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		{vid_valid_i, vid_sof_i, vid_y_i, vid_cb_i, vid_cr_i} = '0;
		slow = 1'b1;
		repeat (6) @(posedge sys_clk_i);
		rstn_i <= 1'b1;
		rchk(VPA_LGAIN_OFS, 32'h3E8);
		rchk(VPA_BCLIP_OFS, 32'hFFFFFFBC);
		rchk(VPA_SAT_OFS, 32'h640);
		rchk(6'h28, 32'h0);
		wb(1'b1, VPA_LGAIN_OFS, 32'hBB8, 4'hF);
		rchk(VPA_LGAIN_OFS, 32'h7D0);
		wb(1'b1, VPA_LGAIN_OFS, 32'h64, 4'h1);
		rchk(VPA_LGAIN_OFS, 32'h764);
		wb(1'b1, VPA_LIFT_OFS, 32'hFFFFEC78, 4'hF);
		rchk(VPA_LIFT_OFS, 32'hFFFFFC18);
		// Ganged gains follow each other by equal steps
		wb(1'b1, VPA_CTRL_OFS, 32'h2, 4'hF);
		wb(1'b1, VPA_CGAIN_OFS, 32'h44C, 4'hF);
		rchk(VPA_LGAIN_OFS, 32'h7C8);
		wb(1'b1, VPA_LGAIN_OFS, 32'h7D0, 4'hF);
		rchk(VPA_CGAIN_OFS, 32'h454);
		wb(1'b1, VPA_CTRL_OFS, 32'h6, 4'hF);
		rchk(VPA_CGAIN_OFS, 32'h3E8);
		rchk(VPA_LIFT_OFS, 32'h0);
		rchk(VPA_CTRL_OFS, 32'h2);
		wb(1'b1, VPA_CTRL_OFS, 32'h0, 4'hF);
		frame(40, -1);
		// Zero gains leave black and centre, then lift and clips act
		wb(1'b1, VPA_CTRL_OFS, 32'h1, 4'hF);
		wb(1'b1, VPA_LGAIN_OFS, 32'h0, 4'hF);
		wb(1'b1, VPA_CGAIN_OFS, 32'h0, 4'hF);
		frame(8, 64);
		wb(1'b1, VPA_LIFT_OFS, 32'h3E8, 4'hF);
		frame(8, 940);
		wb(1'b1, VPA_WSOFT_OFS, 32'h1F4, 4'hF);
		frame(8, 721);
		wb(1'b1, VPA_WHARD_OFS, 32'h1F4, 4'hF);
		frame(8, 502);
		// Full negative lift lands on the black clip, sink never stalls
		slow <= 1'b0;
		wb(1'b1, VPA_LIFT_OFS, 32'hFFFFFC18, 4'hF);
		frame(8, 5);
		rchk(VPA_STAT_OFS, 32'h00060001);
		summarize();
	end
endmodule
bind vpa_top vpa_checker CHKR (.sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.vid_ready_o, .out_valid_o, .out_ready_i, .out_y_o);
`default_nettype wire

// ===== vpa_checker.sv
// Port assertions of the adjuster
`timescale 1ns/100ps
`default_nettype none
module vpa_checker (
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rstn_i,
	// Watched ports
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic       wb_ack_o,
	input wire logic       vid_ready_o,
	input wire logic       out_valid_o,
	input wire logic       out_ready_i,
	input wire logic [9:0] out_y_o
);
	default clocking @(posedge sys_clk_i); endclocking
	// Bus answers one cycle after a request, as one pulse
	property p_ack; disable iff (!rstn_i) wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack late");
	property p_pulse; disable iff (!rstn_i) wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_cause; disable iff (!rstn_i) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	a_cause: assert property (p_cause) else $error("ack without request");
	// Reset quiets every handshake and clears the output luma
	property p_rst; !rstn_i |=> !wb_ack_o && !out_valid_o && !vid_ready_o; endproperty
	a_rst: assert property (p_rst) else $error("busy in reset");
	property p_rsty; !rstn_i |=> out_y_o == 10'h000; endproperty
	a_rsty: assert property (p_rsty) else $error("luma not cleared");
	property p_wake; $rose(rstn_i) |-> ##[1:3] vid_ready_o; endproperty
	a_wake: assert property (p_wake) else $error("input never ready");
	// A stalled sample must not vanish, nor its luma change, under the sink
	property p_hold; disable iff (!rstn_i) out_valid_o && !out_ready_i |=> out_valid_o; endproperty
	a_hold: assert property (p_hold) else $error("valid dropped");
	property p_data; disable iff (!rstn_i)
		out_valid_o && !out_ready_i |=> $stable(out_y_o); endproperty
	a_data: assert property (p_data) else $error("data moved");
endmodule
`default_nettype wire

// ===== vpa_fifo.sv
// Sample FIFO with registered full, empty decoded from the count
`timescale 1ns/100ps
`default_nettype none
module vpa_fifo #(
	parameter int W     = 31,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic                     sys_clk_i,
	input  wire logic                     rstn_i,
	// Streams
	vpa_stream_if.snk                     wr,
	vpa_stream_if.src                     rd,
	// Fill level
	output logic [$clog2(DEPTH):0]        level_o
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]   cnt_reg, cnt_next;
	logic          rdy_reg, rdy_next;
	logic          push, pop;

	// Ready is registered from the next count so the upstream sees a flop and all DEPTH slots stay usable
	always_comb begin
		push     = wr.valid && rdy_reg;
		pop      = rd.ready && (cnt_reg != '0);
		wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
		rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
		cnt_next = AW'(0) + cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		rdy_next = cnt_next < (AW+1)'(DEPTH);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b0;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end

	assign wr.ready = rdy_reg;
	assign rd.valid = cnt_reg != '0;
	assign rd.data  = mem[rp_reg];
	assign level_o  = cnt_reg;
endmodule
`default_nettype wire

// ===== vpa_pkg.sv
// Constants, settings layout and helper functions of the video level and colour adjuster
// Overview of operation
// - With the master enable off every sample leaves exactly as it arrived.
// - With the master enable on every sample gets the held gain, lift, phase and clip settings.
// - A unity-reset command puts every processing setting back to neutral in one step.
// - Luma is scaled by a gain of 0 to 200 percent in 0.1 percent steps, 100 percent unity.
// - A lift of -100 to +100 percent in 0.1 percent steps is added to luma, zero adds nothing.
// - Both chroma components are scaled by a gain of 0 to 200 percent, 100 percent unity.
// - Chroma is rotated by -360 to +360 degrees in 0.1 degree steps, zero leaves it alone.
// - With ganging on, a change to either gain moves both gains by the same amount, unless the other gain stops at 0 or 200 percent.
// - Luma is held up at a black clip level of -6.8 to 50.0 percent, neutral -6.8 percent.
// - Luma is held down at a white clip level of 50.0 to 109.1 percent, neutral 109.1.
// - Luma above a soft white knee of 50.0 to 109.1 percent is compressed, neutral 109.1.
// - Chroma is limited to a saturation level of 50.0 to 160.0 percent, neutral 160.0.
package vpa_pkg;
	// Register map, word aligned byte offsets
	localparam int         VPA_AW        = 6;
	localparam logic [5:0] VPA_CTRL_OFS  = 6'h00;
	localparam logic [5:0] VPA_LGAIN_OFS = 6'h04;
	localparam logic [5:0] VPA_LIFT_OFS  = 6'h08;
	localparam logic [5:0] VPA_CGAIN_OFS = 6'h0C;
	localparam logic [5:0] VPA_PHASE_OFS = 6'h10;
	localparam logic [5:0] VPA_BCLIP_OFS = 6'h14;
	localparam logic [5:0] VPA_WHARD_OFS = 6'h18;
	localparam logic [5:0] VPA_WSOFT_OFS = 6'h1C;
	localparam logic [5:0] VPA_SAT_OFS   = 6'h20;
	localparam logic [5:0] VPA_STAT_OFS  = 6'h24;
	// Control bits
	localparam int VPA_EN_BIT    = 0;
	localparam int VPA_GANG_BIT  = 1;
	localparam int VPA_UNITY_BIT = 2;
	// Setting ranges in tenths of a percent or degree
	localparam int VPA_GAIN_MIN  = 32'sh0;
	localparam int VPA_GAIN_MAX  = 32'sh7D0;
	localparam int VPA_GAIN_UNIT = 32'sh3E8;
	localparam int VPA_LIFT_LIM  = 32'sh3E8;
	localparam int VPA_PH_FULL   = 32'shE10;
	localparam int VPA_PH_HALF   = 32'sh708;
	localparam int VPA_PH_QUART  = 32'sh384;
	localparam int VPA_BLK_MIN   = -32'sh44;
	localparam int VPA_CLIP_LO   = 32'sh1F4;
	localparam int VPA_WHT_MAX   = 32'sh443;
	localparam int VPA_SAT_MAX   = 32'sh640;
	localparam int VPA_PCT_DIV   = 32'sh3E8;
	// Ten-bit video coding
	localparam int VPA_Y_BLACK   = 32'sh40;
	localparam int VPA_Y_SPAN    = 32'sh36C;
	localparam int VPA_C_MID     = 32'sh200;
	localparam int VPA_C_SPAN    = 32'sh1C0;
	localparam int VPA_CODE_MIN  = 32'sh4;
	localparam int VPA_CODE_MAX  = 32'sh3FB;
	localparam int VPA_Q_SHIFT   = 10;
	localparam int VPA_Q_ONE     = 32'sh400;
	// Rotator constants: angle unit is 1/16 of 0.1 degree, results Q14
	localparam int          VPA_CR_ITERS = 12;
	localparam int          VPA_CR_FRAC  = 14;
	localparam int          VPA_CR_ASH   = 4;
	localparam logic [17:0] VPA_CR_K     = 18'h026DD;
	// Sample word: start-of-frame flag over Y, Cb, Cr
	localparam int VPA_DW      = 31;
	localparam int VPA_SOF_BIT = 30;
	localparam int VPA_DEPTH   = 16;

	typedef struct packed {
		logic signed [12:0] lgain;
		logic signed [12:0] lift;
		logic signed [12:0] cgain;
		logic signed [12:0] phase;
		logic signed [12:0] bclip;
		logic signed [12:0] whard;
		logic signed [12:0] wsoft;
		logic signed [12:0] sat;
	} vpa_set_t;

	localparam vpa_set_t VPA_SET_NEUTRAL = '{13'sh3E8, 13'sh0, 13'sh3E8, 13'sh0,
		-13'sh44, 13'sh443, 13'sh443, 13'sh640};

	typedef enum logic [1:0] {VPA_CR_LOAD, VPA_CR_ITER, VPA_CR_DONE} vpa_cr_t;

	function automatic int vpa_clamp(input int v, input int lo, input int hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Tenths of a percent to code steps over a given span
	function automatic int vpa_rel(input int pct, input int span);
		return (pct * span) / VPA_PCT_DIV;
	endfunction

	// Arctangent of 2^-i in rotator angle units
	function automatic int vpa_atan(input int i);
		case (i)
			0: return 32'sh1C20;
			1: return 32'sh109A;
			2: return 32'sh8C6;
			3: return 32'sh474;
			4: return 32'sh23C;
			5: return 32'sh11E;
			6: return 32'sh8F;
			7: return 32'sh48;
			8: return 32'sh24;
			9: return 32'sh12;
			10: return 32'sh9;
			default: return 32'sh4;
		endcase
	endfunction

	// Byte-lane merge of a Wishbone write into an old word
	function automatic logic [31:0] vpa_merge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return r;
	endfunction
endpackage

// ===== vpa_sink.sv
// Downstream sink model with optional random stalls
`timescale 1ns/100ps
`default_nettype none
module vpa_sink (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rstn_i,
	// Stall control and handshake
	input wire logic slow_i,
	output var logic ready_o = 1'b0
);
	int seed = 32'h938CBB93;
	// Stalling half the time backs samples up into the FIFO
	always @(posedge sys_clk_i) ready_o <= rstn_i && (!slow_i || $random(seed) % 2 == 0);
endmodule
`default_nettype wire

// ===== vpa_stream_if.sv
// Valid/ready sample stream between the adjuster and its FIFO
`timescale 1ns/100ps
`default_nettype none
interface vpa_stream_if #(parameter int W = 31);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== vpa_top.sv
// Video level and colour adjuster with Wishbone settings and frame-locked update
`timescale 1ns/100ps
`default_nettype none
module vpa_top #(
	parameter int DEPTH = vpa_pkg::VPA_DEPTH
) (
	// Clock and reset
	input  wire logic                        sys_clk_i,
	input  wire logic                        rstn_i,
	// Wishbone slave
	input  wire logic                        wb_cyc_i,
	input  wire logic                        wb_stb_i,
	input  wire logic                        wb_we_i,
	input  wire logic [vpa_pkg::VPA_AW-1:0]  wb_adr_i,
	input  wire logic [3:0]                  wb_sel_i,
	input  wire logic [31:0]                 wb_dat_i,
	output logic [31:0]                      wb_dat_o,
	output logic                             wb_ack_o,
	// Incoming samples
	input  wire logic                        vid_valid_i,
	output logic                             vid_ready_o,
	input  wire logic                        vid_sof_i,
	input  wire logic [9:0]                  vid_y_i,
	input  wire logic [9:0]                  vid_cb_i,
	input  wire logic [9:0]                  vid_cr_i,
	// Outgoing samples
	output logic                             out_valid_o,
	input  wire logic                        out_ready_i,
	output logic                             out_sof_o,
	output logic [9:0]                       out_y_o,
	output logic [9:0]                       out_cb_o,
	output logic [9:0]                       out_cr_o
);
	import vpa_pkg::*;

	localparam int LW = $clog2(DEPTH) + 1;

	vpa_stream_if #(.W(VPA_DW)) in_if ();
	vpa_stream_if #(.W(VPA_DW)) fo_if ();
	logic [LW-1:0] level;
	logic          adv, load;

	// Input stream into the FIFO
	assign in_if.valid = vid_valid_i;
	assign in_if.data  = {vid_sof_i, vid_y_i, vid_cb_i, vid_cr_i};
	assign vid_ready_o = in_if.ready;
	assign fo_if.ready = adv;

	vpa_fifo #(.W(VPA_DW), .DEPTH(DEPTH)) u_fifo (
		.sys_clk_i (sys_clk_i),
		.rstn_i    (rstn_i),
		.wr        (in_if),
		.rd        (fo_if),
		.level_o   (level)
	);

	// Settings group: software-written shadow copy
	vpa_set_t    set_reg, set_next;
	logic        en_reg, en_next, gang_reg, gang_next, pend_reg, pend_next;
	logic        ack_reg, ack_next, act_en_reg, act_en_next;
	logic [31:0] dat_reg, dat_next;
	logic [15:0] fcnt_reg, fcnt_next;
	logic        wr_hit;
	logic [31:0] wv;
	int          g, d;

	// Writes clamp into the legal range so the datapath never sees an illegal value
	always_comb begin
		set_next  = set_reg;
		en_next   = en_reg;
		gang_next = gang_reg;
		pend_next = pend_reg;
		dat_next  = dat_reg;
		ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
		wr_hit    = ack_next && wb_we_i;
		wv        = 32'h0;
		g         = 0;
		d         = 0;
		if (load) begin
			pend_next = 1'b0;
		end
		if (wr_hit) begin
			pend_next = 1'b1;
			case (wb_adr_i)
				VPA_CTRL_OFS: begin
					wv        = vpa_merge({29'h0, 1'b0, gang_reg, en_reg}, wb_dat_i, wb_sel_i);
					en_next   = wv[VPA_EN_BIT];
					gang_next = wv[VPA_GANG_BIT];
					if (wv[VPA_UNITY_BIT]) begin
						set_next = VPA_SET_NEUTRAL;
					end
				end
				VPA_LGAIN_OFS: begin
					wv = vpa_merge(32'(set_reg.lgain), wb_dat_i, wb_sel_i);
					g  = vpa_clamp(int'($signed(wv)), VPA_GAIN_MIN, VPA_GAIN_MAX);
					d  = g - int'(set_reg.lgain);
					set_next.lgain = 13'(g);
					if (gang_reg) begin
						set_next.cgain = 13'(vpa_clamp(int'(set_reg.cgain) + d, VPA_GAIN_MIN,
							VPA_GAIN_MAX));
					end
				end
				VPA_CGAIN_OFS: begin
					wv = vpa_merge(32'(set_reg.cgain), wb_dat_i, wb_sel_i);
					g  = vpa_clamp(int'($signed(wv)), VPA_GAIN_MIN, VPA_GAIN_MAX);
					d  = g - int'(set_reg.cgain);
					set_next.cgain = 13'(g);
					if (gang_reg) begin
						set_next.lgain = 13'(vpa_clamp(int'(set_reg.lgain) + d, VPA_GAIN_MIN,
							VPA_GAIN_MAX));
					end
				end
				VPA_LIFT_OFS: begin
					wv = vpa_merge(32'(set_reg.lift), wb_dat_i, wb_sel_i);
					set_next.lift = 13'(vpa_clamp(int'($signed(wv)), -VPA_LIFT_LIM,
						VPA_LIFT_LIM));
				end
				VPA_PHASE_OFS: begin
					wv = vpa_merge(32'(set_reg.phase), wb_dat_i, wb_sel_i);
					set_next.phase = 13'(vpa_clamp(int'($signed(wv)), -VPA_PH_FULL,
						VPA_PH_FULL));
				end
				VPA_BCLIP_OFS: begin
					wv = vpa_merge(32'(set_reg.bclip), wb_dat_i, wb_sel_i);
					set_next.bclip = 13'(vpa_clamp(int'($signed(wv)), VPA_BLK_MIN,
						VPA_CLIP_LO));
				end
				VPA_WHARD_OFS: begin
					wv = vpa_merge(32'(set_reg.whard), wb_dat_i, wb_sel_i);
					set_next.whard = 13'(vpa_clamp(int'($signed(wv)), VPA_CLIP_LO,
						VPA_WHT_MAX));
				end
				VPA_WSOFT_OFS: begin
					wv = vpa_merge(32'(set_reg.wsoft), wb_dat_i, wb_sel_i);
					set_next.wsoft = 13'(vpa_clamp(int'($signed(wv)), VPA_CLIP_LO,
						VPA_WHT_MAX));
				end
				VPA_SAT_OFS: begin
					wv = vpa_merge(32'(set_reg.sat), wb_dat_i, wb_sel_i);
					set_next.sat = 13'(vpa_clamp(int'($signed(wv)), VPA_CLIP_LO,
						VPA_SAT_MAX));
				end
				default: begin
					pend_next = pend_reg && !load; // Ignored write must not undo a load clear
				end
			endcase
		end
		// Read data, fields sign-extended; unmapped offsets read zero
		if (ack_next && !wb_we_i) begin
			case (wb_adr_i)
				VPA_CTRL_OFS:  dat_next = {30'h0, gang_reg, en_reg};
				VPA_LGAIN_OFS: dat_next = 32'(set_reg.lgain);
				VPA_LIFT_OFS:  dat_next = 32'(set_reg.lift);
				VPA_CGAIN_OFS: dat_next = 32'(set_reg.cgain);
				VPA_PHASE_OFS: dat_next = 32'(set_reg.phase);
				VPA_BCLIP_OFS: dat_next = 32'(set_reg.bclip);
				VPA_WHARD_OFS: dat_next = 32'(set_reg.whard);
				VPA_WSOFT_OFS: dat_next = 32'(set_reg.wsoft);
				VPA_SAT_OFS:   dat_next = 32'(set_reg.sat);
				VPA_STAT_OFS:  dat_next = {fcnt_reg, 7'h00, 5'(level), 1'b0, pend_reg,
					gang_reg, act_en_reg};
				default:       dat_next = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			set_reg  <= VPA_SET_NEUTRAL;
			en_reg   <= 1'b0;
			gang_reg <= 1'b0;
			pend_reg <= 1'b0;
			ack_reg  <= 1'b0;
			dat_reg  <= 32'h0;
		end else begin
			set_reg  <= set_next;
			en_reg   <= en_next;
			gang_reg <= gang_next;
			pend_reg <= pend_next;
			ack_reg  <= ack_next;
			dat_reg  <= dat_next;
		end
	end

	// Rotator group: background CORDIC turns the shadow phase into cos and sin
	vpa_cr_t            cr_st_reg, cr_st_next;
	logic signed [17:0] cx_reg, cx_next, cy_reg, cy_next, cz_reg, cz_next;
	logic [3:0]         ci_reg, ci_next;
	logic               cneg_reg, cneg_next;
	logic signed [17:0] cos_reg, cos_next, sin_reg, sin_next;
	int                 p;

	// Runs forever so the latest phase is ready whenever a frame starts
	always_comb begin
		cr_st_next = cr_st_reg;
		cx_next    = cx_reg;
		cy_next    = cy_reg;
		cz_next    = cz_reg;
		ci_next    = ci_reg;
		cneg_next  = cneg_reg;
		cos_next   = cos_reg;
		sin_next   = sin_reg;
		p          = int'(set_reg.phase);
		case (cr_st_reg)
			VPA_CR_LOAD: begin
				if (p > VPA_PH_HALF) p = p - VPA_PH_FULL;
				if (p < -VPA_PH_HALF) p = p + VPA_PH_FULL;
				cneg_next = (p > VPA_PH_QUART) || (p < -VPA_PH_QUART);
				if (p > VPA_PH_QUART) p = p - VPA_PH_HALF;
				if (p < -VPA_PH_QUART) p = p + VPA_PH_HALF;
				cx_next    = VPA_CR_K;
				cy_next    = 18'sh0;
				cz_next    = 18'(p <<< VPA_CR_ASH);
				ci_next    = 4'h0;
				cr_st_next = VPA_CR_ITER;
			end
			VPA_CR_ITER: begin
				if (cz_reg >= 0) begin
					cx_next = cx_reg - (cy_reg >>> ci_reg);
					cy_next = cy_reg + (cx_reg >>> ci_reg);
					cz_next = 18'(int'(cz_reg) - vpa_atan(int'(ci_reg)));
				end else begin
					cx_next = cx_reg + (cy_reg >>> ci_reg);
					cy_next = cy_reg - (cx_reg >>> ci_reg);
					cz_next = 18'(int'(cz_reg) + vpa_atan(int'(ci_reg)));
				end
				ci_next = 4'(ci_reg + 1'b1);
				if (int'(ci_reg) == VPA_CR_ITERS - 1) cr_st_next = VPA_CR_DONE;
			end
			VPA_CR_DONE: begin
				cos_next   = cneg_reg ? -cx_reg : cx_reg;
				sin_next   = cneg_reg ? -cy_reg : cy_reg;
				cr_st_next = VPA_CR_LOAD;
			end
			default: cr_st_next = VPA_CR_LOAD;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			cr_st_reg <= VPA_CR_LOAD;
			cx_reg    <= 18'sh0;
			cy_reg    <= 18'sh0;
			cz_reg    <= 18'sh0;
			ci_reg    <= 4'h0;
			cneg_reg  <= 1'b0;
			cos_reg   <= 18'sh4000;
			sin_reg   <= 18'sh0;
		end else begin
			cr_st_reg <= cr_st_next;
			cx_reg    <= cx_next;
			cy_reg    <= cy_next;
			cz_reg    <= cz_next;
			ci_reg    <= ci_next;
			cneg_reg  <= cneg_next;
			cos_reg   <= cos_next;
			sin_reg   <= sin_next;
		end
	end

	// Active group: per-frame copy in datapath units, loaded at start of frame
	logic signed [12:0] lg_reg, lg_next, cg_reg, cg_next, lift_reg, lift_next;
	logic signed [12:0] blk_reg, blk_next, wht_reg, wht_next, knee_reg, knee_next;
	logic signed [12:0] sat_reg, sat_next;
	logic signed [17:0] acos_reg, acos_next, asin_reg, asin_next;

	// Swapping only at frame start keeps a picture from showing two settings, save the sample directly ahead of a start, which gets the new hard clips
	always_comb begin
		load        = fo_if.valid && adv && fo_if.data[VPA_SOF_BIT];
		act_en_next = act_en_reg;
		lg_next     = lg_reg;
		cg_next     = cg_reg;
		lift_next   = lift_reg;
		blk_next    = blk_reg;
		wht_next    = wht_reg;
		knee_next   = knee_reg;
		sat_next    = sat_reg;
		acos_next   = acos_reg;
		asin_next   = asin_reg;
		fcnt_next   = fcnt_reg;
		if (load) begin
			act_en_next = en_reg;
			lg_next     = 13'(vpa_rel(int'(set_reg.lgain), VPA_Q_ONE));
			cg_next     = 13'(vpa_rel(int'(set_reg.cgain), VPA_Q_ONE));
			lift_next   = 13'(vpa_rel(int'(set_reg.lift), VPA_Y_SPAN));
			blk_next    = 13'(vpa_rel(int'(set_reg.bclip), VPA_Y_SPAN));
			wht_next    = 13'(vpa_rel(int'(set_reg.whard), VPA_Y_SPAN));
			knee_next   = 13'(vpa_rel(int'(set_reg.wsoft), VPA_Y_SPAN));
			sat_next    = 13'(vpa_rel(int'(set_reg.sat), VPA_C_SPAN));
			acos_next   = cos_reg;
			asin_next   = sin_reg;
			fcnt_next   = 16'(fcnt_reg + 1'b1);
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			act_en_reg <= 1'b0;
			lg_reg     <= 13'sh400;
			cg_reg     <= 13'sh400;
			lift_reg   <= 13'sh0;
			blk_reg    <= -13'sh3B;
			wht_reg    <= 13'sh3BB;
			knee_reg   <= 13'sh3BB;
			sat_reg    <= 13'sh2CC;
			acos_reg   <= 18'sh4000;
			asin_reg   <= 18'sh0;
			fcnt_reg   <= 16'h0;
		end else begin
			act_en_reg <= act_en_next;
			lg_reg     <= lg_next;
			cg_reg     <= cg_next;
			lift_reg   <= lift_next;
			blk_reg    <= blk_next;
			wht_reg    <= wht_next;
			knee_reg   <= knee_next;
			sat_reg    <= sat_next;
			acos_reg   <= acos_next;
			asin_reg   <= asin_next;
			fcnt_reg   <= fcnt_next;
		end
	end

	// Pipeline group: stage 1 gain/lift, stage 2 phase/soft clip, output hard clips
	logic               s1_v_reg, s1_v_next, s2_v_reg, s2_v_next, o_v_reg, o_v_next;
	logic               s1_byp_reg, s1_byp_next, s2_byp_reg, s2_byp_next;
	logic [30:0]        s1_raw_reg, s1_raw_next, s2_raw_reg, s2_raw_next;
	logic signed [12:0] s1_y_reg, s1_y_next, s1_cb_reg, s1_cb_next, s1_cr_reg, s1_cr_next;
	logic signed [12:0] s2_y_reg, s2_y_next, s2_cb_reg, s2_cb_next, s2_cr_reg, s2_cr_next;
	logic [30:0]        o_reg, o_next;
	int                 yv, cbv, crv, sl;

	// One stall term for all stages keeps the pipe in lock-step with the output
	always_comb begin
		adv         = !o_v_reg || out_ready_i;
		s1_v_next   = s1_v_reg;
		s2_v_next   = s2_v_reg;
		o_v_next    = o_v_reg;
		s1_byp_next = s1_byp_reg;
		s2_byp_next = s2_byp_reg;
		s1_raw_next = s1_raw_reg;
		s2_raw_next = s2_raw_reg;
		s1_y_next   = s1_y_reg;
		s1_cb_next  = s1_cb_reg;
		s1_cr_next  = s1_cr_reg;
		s2_y_next   = s2_y_reg;
		s2_cb_next  = s2_cb_reg;
		s2_cr_next  = s2_cr_reg;
		o_next      = o_reg;
		yv          = 0;
		cbv         = 0;
		crv         = 0;
		sl          = int'(sat_reg);
		if (adv) begin
			// Stage 1 uses next-frame values so the first sample of a frame is already new
			s1_v_next   = fo_if.valid;
			s1_raw_next = fo_if.data;
			s1_byp_next = !act_en_next;
			yv  = int'(fo_if.data[29:20]) - VPA_Y_BLACK;
			cbv = int'(fo_if.data[19:10]) - VPA_C_MID;
			crv = int'(fo_if.data[9:0]) - VPA_C_MID;
			s1_y_next  = 13'(((yv * int'(lg_next)) >>> VPA_Q_SHIFT) + int'(lift_next));
			s1_cb_next = 13'((cbv * int'(cg_next)) >>> VPA_Q_SHIFT);
			s1_cr_next = 13'((crv * int'(cg_next)) >>> VPA_Q_SHIFT);
			// Stage 2: rotate, then compress by half above the soft knee
			s2_v_next   = s1_v_reg;
			s2_raw_next = s1_raw_reg;
			s2_byp_next = s1_byp_reg;
			s2_cb_next  = 13'((int'(s1_cb_reg) * int'(acos_reg) - int'(s1_cr_reg)
				* int'(asin_reg)) >>> VPA_CR_FRAC);
			s2_cr_next  = 13'((int'(s1_cb_reg) * int'(asin_reg) + int'(s1_cr_reg)
				* int'(acos_reg)) >>> VPA_CR_FRAC);
			s2_y_next   = (s1_y_reg > knee_reg) ?
				13'(knee_reg + ((s1_y_reg - knee_reg) >>> 1)) : s1_y_reg;
			// Output: hard clips, then legal code range; bypass takes the raw word
			o_v_next = s2_v_reg;
			yv  = vpa_clamp(int'(s2_y_reg), int'(blk_reg), int'(wht_reg));
			cbv = vpa_clamp(int'(s2_cb_reg), -sl, sl);
			crv = vpa_clamp(int'(s2_cr_reg), -sl, sl);
			yv  = vpa_clamp(yv + VPA_Y_BLACK, VPA_CODE_MIN, VPA_CODE_MAX);
			cbv = vpa_clamp(cbv + VPA_C_MID, VPA_CODE_MIN, VPA_CODE_MAX);
			crv = vpa_clamp(crv + VPA_C_MID, VPA_CODE_MIN, VPA_CODE_MAX);
			o_next = s2_byp_reg ? s2_raw_reg :
				{s2_raw_reg[VPA_SOF_BIT], 10'(yv), 10'(cbv), 10'(crv)};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!rstn_i) begin
			s1_v_reg   <= 1'b0;
			s2_v_reg   <= 1'b0;
			o_v_reg    <= 1'b0;
			s1_byp_reg <= 1'b1;
			s2_byp_reg <= 1'b1;
			s1_raw_reg <= '0;
			s2_raw_reg <= '0;
			s1_y_reg   <= 13'sh0;
			s1_cb_reg  <= 13'sh0;
			s1_cr_reg  <= 13'sh0;
			s2_y_reg   <= 13'sh0;
			s2_cb_reg  <= 13'sh0;
			s2_cr_reg  <= 13'sh0;
			o_reg      <= '0;
		end else begin
			s1_v_reg   <= s1_v_next;
			s2_v_reg   <= s2_v_next;
			o_v_reg    <= o_v_next;
			s1_byp_reg <= s1_byp_next;
			s2_byp_reg <= s2_byp_next;
			s1_raw_reg <= s1_raw_next;
			s2_raw_reg <= s2_raw_next;
			s1_y_reg   <= s1_y_next;
			s1_cb_reg  <= s1_cb_next;
			s1_cr_reg  <= s1_cr_next;
			s2_y_reg   <= s2_y_next;
			s2_cb_reg  <= s2_cb_next;
			s2_cr_reg  <= s2_cr_next;
			o_reg      <= o_next;
		end
	end

	// Outputs straight from flops
	assign wb_ack_o    = ack_reg;
	assign wb_dat_o    = dat_reg;
	assign out_valid_o = o_v_reg;
	assign out_sof_o   = o_reg[VPA_SOF_BIT];
	assign out_y_o     = o_reg[29:20];
	assign out_cb_o    = o_reg[19:10];
	assign out_cr_o    = o_reg[9:0];
endmodule
`default_nettype wire
